/* File: core/dbs_pkg.sv */
// constants and types shared by the battery status serial port
package dbs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// slave address and register map
	localparam logic [4:0] DEV_ADDR_HI = 5'h17; // fixed upper address bits 10111
	localparam logic [7:0] REG_STATE = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h01;
	localparam logic [7:0] REG_SOFT_RESET = 8'h0f;
	localparam logic [7:0] SOFT_RESET_KEY = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// configuration field positions and value after reset
	localparam logic [5:0] CONFIG_RESET = 6'h00;
	localparam int CFG_CHG_OFF_POS = 5;
	localparam int CFG_FORCE_LSB = 4;
	localparam int CFG_HYST_LSB = 2;
	localparam int CFG_THR1_POS = 1;
	localparam int CFG_THR2_POS = 0;

	////////////////////////////////////////////////////////////////////////////
	// state register field positions
	localparam int ST_B_IN_POS = 7;
	localparam int ST_A_IN_POS = 6;
	localparam int ST_SRC_LSB = 4;
	localparam int ST_B_LVL_LSB = 2;
	localparam int ST_A_LVL_LSB = 0;

	////////////////////////////////////////////////////////////////////////////
	// bit counting and timing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = (SPIKE_NS / CLK_PERIOD_NS) < 1 ? 1 : (SPIKE_NS / CLK_PERIOD_NS);
	localparam int FILTER_W = 13;

	////////////////////////////////////////////////////////////////////////////
	// serial transfer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_CMD,
		ST_ACK_CMD,
		ST_WDATA,
		ST_ACK_WDATA,
		ST_RDATA,
		ST_RACK
	} dbs_bus_state_t;

endpackage

/* File: core/dbs_pin_filter.sv */
// three-stage synchroniser with agreement filter for asynchronous pins
module dbs_pin_filter #(
	parameter int W = 13
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// pins
	input wire logic [W-1:0] raw_in,
	// filtered levels
	output logic [W-1:0] clean_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} dbs_filt_t;

	dbs_filt_t cur_ff;
	dbs_filt_t nxt_cur;

	////////////////////////////////////////////////////////////////////////////
	// a bit changes only when stages two and three agree
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.s1 = raw_in;
		nxt_cur.s2 = cur_ff.s1;
		nxt_cur.s3 = cur_ff.s2;
		nxt_cur.q = (cur_ff.s2 & cur_ff.s3) | (cur_ff.q & (cur_ff.s2 ^ cur_ff.s3));
	end

	// state register
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign clean_out = cur_ff.q;

	////////////////////////////////////////////////////////////////////////////
	// a lone one-cycle spike never reaches the output
	spike_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
		(($past(cur_ff.s2 ^ cur_ff.s3) & (cur_ff.q ^ $past(cur_ff.q))) == '0))
		else $error("filtered level moved on a disagreeing sample");

endmodule

/* File: core/dbs_status_monitor.sv */
// status change detector that holds the interrupt until the state is read
module dbs_status_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// status and clear
	input wire logic [7:0] status_in,
	input wire logic clear_pulse,
	// interrupt
	output logic irq_pending
);

	typedef struct packed {
		logic [7:0] prev;
		logic primed;
		logic pending;
	} dbs_mon_t;

	dbs_mon_t cur_ff;
	dbs_mon_t nxt_cur;
	logic change;

	////////////////////////////////////////////////////////////////////////////
	// change sets pending; a read clears it; set wins over clear
	always_comb
	begin
		nxt_cur = cur_ff;
		change = cur_ff.primed && (status_in != cur_ff.prev);
		nxt_cur.prev = status_in;
		nxt_cur.primed = 1'b1;
		if (change)
			nxt_cur.pending = 1'b1;
		else if (clear_pulse)
			nxt_cur.pending = 1'b0;
	end

	// state register
	always_ff @(posedge clock)
	begin
		if (rst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign irq_pending = cur_ff.pending;

	////////////////////////////////////////////////////////////////////////////
	// every status change raises the interrupt next cycle
	irq_raise_a: assert property (@(posedge clock) disable iff (rst)
		change |=> irq_pending)
		else $error("status changed but interrupt not raised");

	// a read with no fresh change drops it; without a read it holds
	irq_clear_a: assert property (@(posedge clock) disable iff (rst)
		(irq_pending && !clear_pulse) |=> irq_pending)
		else $error("interrupt dropped without a state read");

	irq_drop_a: assert property (@(posedge clock) disable iff (rst)
		(clear_pulse && !change) |=> !irq_pending)
		else $error("interrupt held after a state read");

endmodule

/* File: core/dbs_serial_port.sv */
// two-wire serial register port of the dual battery controller
//
// Contract
// - address upper five bits are 10111
// - two low address bits follow select pins
// - address LSB zero writes, one reads
// - data sampled on stable high clock
// - matching address acknowledged on ninth pulse
// - register byte sent, device acknowledges it
// - one data byte written, device acknowledges
// - write command byte picks target register
// - read: pointer write, restart, return register
// - state, configuration and reset registers decoded
// - configuration six low bits reset zero
// - reset register write restores defaults
// - state register bit layout as specified
// - inserted flag follows identification pin level
// - status change asserts active-low interrupt
// - hardware reset cuts power, resets port
// - glitches under spike limit are ignored
// - zero byte to reset register restores defaults
// - configuration fields: source, hysteresis, thresholds
// - source field codes A, B, adapter
module dbs_serial_port (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// address select and hardware reset pins
	input wire logic addr_select_high_pin,
	input wire logic addr_select_low_pin,
	input wire logic hw_reset_n_in,
	// battery status inputs
	input wire logic battery_a_present_pin,
	input wire logic battery_b_present_pin,
	input wire logic [1:0] supply_source_state,
	input wire logic [1:0] batt_b_level_field,
	input wire logic [1:0] batt_a_level_field,
	// interrupt and power path
	output logic irq_n_out,
	output logic power_path_en,
	// configuration outputs
	output logic [1:0] source_force_select,
	output logic [1:0] hysteresis_select,
	output logic thr1_select,
	output logic thr2_select,
	output logic charger_off
);

	typedef struct packed {
		dbs_pkg::dbs_bus_state_t state;
		logic [7:0] shift;
		logic [3:0] cnt;
		logic rw;
		logic [7:0] ptr;
		logic [5:0] cfg;
		logic sda_oe;
		logic scl_d;
		logic sda_d;
		logic racked;
		logic pwr_en;
	} dbs_port_t;

	dbs_port_t cur_ff;
	dbs_port_t nxt_cur;
	logic [dbs_pkg::FILTER_W-1:0] raw_pins;
	logic [dbs_pkg::FILTER_W-1:0] clean_pins;
	logic [7:0] status_c;
	logic scl_c;
	logic sda_c;
	logic ad_hi_c;
	logic ad_lo_c;
	logic hw_n_c;
	logic rst_int;
	logic [6:0] dev_addr;
	logic [7:0] rd_data;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic clr_read;
	logic irq_pending;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and status word assembly
	assign raw_pins = {scl_in, sda_in, addr_select_high_pin, addr_select_low_pin, hw_reset_n_in,
		battery_b_present_pin, battery_a_present_pin, supply_source_state,
		batt_b_level_field, batt_a_level_field};

	dbs_pin_filter #(
		.W(dbs_pkg::FILTER_W)
	) dbs_pin_filter_inst (
		.clock(clock),
		.sys_rst(sys_rst),
		.raw_in(raw_pins),
		.clean_out(clean_pins)
	);

	// split filtered pins; inserted flags pass through the filter like the other status pins
	assign scl_c = clean_pins[12];
	assign sda_c = clean_pins[11];
	assign ad_hi_c = clean_pins[10];
	assign ad_lo_c = clean_pins[9];
	assign hw_n_c = clean_pins[8];
	assign status_c = clean_pins[7:0];
	assign rst_int = sys_rst | ~hw_n_c;
	assign dev_addr = {dbs_pkg::DEV_ADDR_HI, ad_hi_c, ad_lo_c};

	////////////////////////////////////////////////////////////////////////////
	// bus events from the filtered lines
	assign scl_rise = scl_c && !cur_ff.scl_d;
	assign scl_fall = !scl_c && cur_ff.scl_d;
	assign start_c = scl_c && cur_ff.scl_d && cur_ff.sda_d && !sda_c;
	assign stop_c = scl_c && cur_ff.scl_d && !cur_ff.sda_d && sda_c;

	// read data selection by register pointer
	always_comb
	begin
		if (cur_ff.ptr == dbs_pkg::REG_STATE)
			rd_data = status_c;
		else if (cur_ff.ptr == dbs_pkg::REG_CONFIG)
			rd_data = {2'b00, cur_ff.cfg};
		else
			rd_data = dbs_pkg::RD_UNMAPPED;
	end

	////////////////////////////////////////////////////////////////////////////
	// transfer state machine and register file
	always_comb
	begin
		nxt_cur = cur_ff;
		clr_read = 1'b0;
		nxt_cur.scl_d = scl_c;
		nxt_cur.sda_d = sda_c;
		nxt_cur.pwr_en = 1'b1;
		if (start_c)
		begin
			nxt_cur.state = dbs_pkg::ST_ADDR; // also a repeated start
			nxt_cur.cnt = '0;
			nxt_cur.sda_oe = 1'b0;
		end
		else if (stop_c)
		begin
			nxt_cur.state = dbs_pkg::ST_IDLE;
			nxt_cur.sda_oe = 1'b0;
		end
		else
		begin
			case (cur_ff.state)
				dbs_pkg::ST_ADDR, dbs_pkg::ST_CMD, dbs_pkg::ST_WDATA:
				begin
					if (scl_rise && cur_ff.cnt != dbs_pkg::BYTE_BITS)
					begin
						nxt_cur.shift = {cur_ff.shift[6:0], sda_c};
						nxt_cur.cnt = cur_ff.cnt + 4'h1;
					end
					else if (scl_fall && cur_ff.cnt == dbs_pkg::BYTE_BITS)
					begin
						nxt_cur.cnt = '0;
						if (cur_ff.state == dbs_pkg::ST_ADDR)
						begin
							if (cur_ff.shift[7:1] == dev_addr)
							begin
								nxt_cur.state = dbs_pkg::ST_ACK_ADDR;
								nxt_cur.rw = cur_ff.shift[0];
								nxt_cur.sda_oe = 1'b1;
							end
							else
								nxt_cur.state = dbs_pkg::ST_IDLE;
						end
						else if (cur_ff.state == dbs_pkg::ST_CMD)
						begin
							nxt_cur.ptr = cur_ff.shift;
							nxt_cur.state = dbs_pkg::ST_ACK_CMD;
							nxt_cur.sda_oe = 1'b1;
						end
						else
						begin
							if (cur_ff.ptr == dbs_pkg::REG_CONFIG)
								nxt_cur.cfg = cur_ff.shift[5:0];
							else if (cur_ff.ptr == dbs_pkg::REG_SOFT_RESET && cur_ff.shift == dbs_pkg::SOFT_RESET_KEY)
								nxt_cur.cfg = dbs_pkg::CONFIG_RESET;
							nxt_cur.state = dbs_pkg::ST_ACK_WDATA;
							nxt_cur.sda_oe = 1'b1;
						end
					end
				end
				dbs_pkg::ST_ACK_ADDR, dbs_pkg::ST_ACK_CMD, dbs_pkg::ST_ACK_WDATA:
				begin
					if (scl_fall)
					begin
						nxt_cur.sda_oe = 1'b0;
						if (cur_ff.state == dbs_pkg::ST_ACK_ADDR && cur_ff.rw)
						begin
							nxt_cur.state = dbs_pkg::ST_RDATA;
							nxt_cur.shift = rd_data;
							nxt_cur.sda_oe = ~rd_data[7];
							clr_read = (cur_ff.ptr == dbs_pkg::REG_STATE);
						end
						else if (cur_ff.state == dbs_pkg::ST_ACK_ADDR)
							nxt_cur.state = dbs_pkg::ST_CMD;
						else
							nxt_cur.state = dbs_pkg::ST_WDATA;
					end
				end
				dbs_pkg::ST_RDATA:
				begin
					if (scl_rise)
						nxt_cur.cnt = cur_ff.cnt + 4'h1;
					else if (scl_fall)
					begin
						if (cur_ff.cnt == dbs_pkg::BYTE_BITS)
						begin
							nxt_cur.sda_oe = 1'b0; // release for master acknowledge
							nxt_cur.state = dbs_pkg::ST_RACK;
						end
						else
						begin
							nxt_cur.shift = {cur_ff.shift[6:0], 1'b0};
							nxt_cur.sda_oe = ~cur_ff.shift[6];
						end
					end
				end
				dbs_pkg::ST_RACK:
				begin
					if (scl_rise)
						nxt_cur.racked = !sda_c;
					else if (scl_fall)
					begin
						nxt_cur.cnt = '0;
						if (cur_ff.racked)
						begin
							nxt_cur.state = dbs_pkg::ST_RDATA; // master wants another byte
							nxt_cur.shift = rd_data;
							nxt_cur.sda_oe = ~rd_data[7];
							clr_read = (cur_ff.ptr == dbs_pkg::REG_STATE);
						end
						else
							nxt_cur.state = dbs_pkg::ST_IDLE;
					end
				end
				default:
				begin
					nxt_cur.state = dbs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// state register; hardware reset also clears configuration
	always_ff @(posedge clock)
	begin
		if (rst_int)
		begin
			cur_ff <= '0;
			cur_ff.cfg <= dbs_pkg::CONFIG_RESET;
		end
		else
			cur_ff <= nxt_cur;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt generation
	dbs_status_monitor dbs_status_monitor_inst (
		.clock(clock),
		.rst(rst_int),
		.status_in(status_c),
		.clear_pulse(clr_read),
		.irq_pending(irq_pending)
	);

	// outputs
	assign sda_out = 1'b0; // open drain: only ever pulls low
	assign sda_oe = cur_ff.sda_oe;
	assign irq_n_out = ~irq_pending;
	assign power_path_en = cur_ff.pwr_en;
	assign source_force_select = cur_ff.cfg[dbs_pkg::CFG_FORCE_LSB +: 2];
	assign hysteresis_select = cur_ff.cfg[dbs_pkg::CFG_HYST_LSB +: 2];
	assign thr1_select = cur_ff.cfg[dbs_pkg::CFG_THR1_POS];
	assign thr2_select = cur_ff.cfg[dbs_pkg::CFG_THR2_POS];
	assign charger_off = cur_ff.cfg[dbs_pkg::CFG_CHG_OFF_POS];

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking dbs_cb @(posedge clock);
	endclocking
	default disable iff (rst_int);

	sequence addr_done_s;
		cur_ff.state == dbs_pkg::ST_ADDR && scl_fall && !start_c && !stop_c && cur_ff.cnt == dbs_pkg::BYTE_BITS;
	endsequence

	sequence wdata_done_s;
		cur_ff.state == dbs_pkg::ST_WDATA && scl_fall && !start_c && !stop_c && cur_ff.cnt == dbs_pkg::BYTE_BITS;
	endsequence

	addr_ack_a: assert property (addr_done_s ##0 (cur_ff.shift[7:1] == dev_addr)
		|=> sda_oe && cur_ff.state == dbs_pkg::ST_ACK_ADDR && cur_ff.rw == $past(cur_ff.shift[0]))
		else $error("matching address not acknowledged");

	addr_nack_a: assert property (addr_done_s ##0 (cur_ff.shift[7:1] != dev_addr)
		|=> !sda_oe && cur_ff.state == dbs_pkg::ST_IDLE)
		else $error("foreign address acknowledged");

	sda_stable_a: assert property (($changed(cur_ff.sda_oe) && !$past(start_c) && !$past(stop_c))
		|-> !cur_ff.scl_d)
		else $error("data line changed while clock high");

	cfg_write_a: assert property ((wdata_done_s ##0 (cur_ff.ptr == dbs_pkg::REG_CONFIG))
		|=> cur_ff.cfg == $past(cur_ff.shift[5:0]) ##1 (cur_ff.state == dbs_pkg::ST_ACK_WDATA || !sda_oe))
		else $error("configuration write lost");

	soft_reset_a: assert property (wdata_done_s ##0 (cur_ff.ptr == dbs_pkg::REG_SOFT_RESET)
		##0 (cur_ff.shift == dbs_pkg::SOFT_RESET_KEY) |=> cur_ff.cfg == dbs_pkg::CONFIG_RESET)
		else $error("soft reset did not restore configuration");

	ro_write_a: assert property (wdata_done_s ##0 (cur_ff.ptr != dbs_pkg::REG_CONFIG)
		##0 (cur_ff.ptr != dbs_pkg::REG_SOFT_RESET) |=> $stable(cur_ff.cfg) && sda_oe)
		else $error("read-only write altered a register or was not acknowledged");

	read_load_a: assert property ((cur_ff.state == dbs_pkg::ST_ACK_ADDR && cur_ff.rw && scl_fall
		&& !start_c && !stop_c) |=> cur_ff.shift == $past(rd_data) && sda_oe == !$past(rd_data[7]))
		else $error("read data not loaded after address acknowledge");

	pwr_cut_a: assert property (@(posedge clock) disable iff (sys_rst)
		!hw_n_c |=> !power_path_en && cur_ff.state == dbs_pkg::ST_IDLE && !sda_oe)
		else $error("power path not cut under hardware reset");

endmodule

/* File: tb/dbs_bus_master.sv */
// behavioural serial bus master that drives the port's clock and data lines
module dbs_bus_master (
	// clock
	input wire logic clock,
	// serial bus, data pulled low while sda_pull is high
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int QTR = 6;

	// bus idle with both lines released high
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	////////////////////////////////////////////////////////////
	// one quarter of a bit time
	task automatic qtr();
		repeat (QTR) @(posedge clock);
	endtask

	// start or repeated start from a released data line
	task automatic start_cond();
		sda_pull <= 1'b0;
		qtr();
		scl <= 1'b1;
		qtr();
		sda_pull <= 1'b1;
		qtr();
		scl <= 1'b0;
		qtr();
	endtask

	// stop, data rises while clock is high
	task automatic stop_cond();
		sda_pull <= 1'b1;
		qtr();
		scl <= 1'b1;
		qtr();
		sda_pull <= 1'b0;
		qtr();
		qtr();
	endtask

	// one bit, data held over the high phase, wire read at its end
	task automatic bit_io(input logic b, output logic r);
		sda_pull <= ~b;
		qtr();
		scl <= 1'b1;
		qtr();
		qtr();
		r = sda;
		scl <= 1'b0;
		qtr();
	endtask

	// eight bits msb first, then the acknowledge pulse
	task automatic byte_io(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(ack_out, ack_in);
	endtask

	////////////////////////////////////////////////////////////
	// register write, abandoned after a missing address acknowledge
	task automatic write_reg(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, output logic [2:0] nak);
		logic [7:0] rx;
		nak = 3'h7;
		start_cond();
		byte_io({a, 1'b0}, 1'b1, rx, nak[2]);
		if (nak[2] === 1'b0)
		begin
			byte_io(r, 1'b1, rx, nak[1]);
			byte_io(d, 1'b1, rx, nak[0]);
		end
		stop_cond();
	endtask

	// pointer write, repeated start, two bytes read, only the last one not acknowledged
	task automatic read_reg(input logic [6:0] a, input logic [7:0] r, output logic [15:0] d, output logic [2:0] nak);
		logic [7:0] rx;
		nak = 3'h7;
		d = 16'hxxxx;
		start_cond();
		byte_io({a, 1'b0}, 1'b1, rx, nak[2]);
		if (nak[2] === 1'b0)
		begin
			byte_io(r, 1'b1, rx, nak[1]);
			start_cond();
			byte_io({a, 1'b1}, 1'b1, rx, nak[0]);
			byte_io(8'hff, 1'b0, d[15:8], rx[0]); // master acknowledge asks for more
			byte_io(8'hff, 1'b1, d[7:0], rx[0]);
		end
		stop_cond();
	endtask
endmodule

/* File: tb/dual_battery_status_i2c_port_tb.sv */
// self-checking testbench of the battery status serial port
module dual_battery_status_i2c_port_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic clock, sys_rst, scl, sda_pull, sda_wire, sda_out, sda_oe;
	logic addr_hi, addr_lo, hw_rst_n, bat_a, bat_b, irq_n_out, power_path_en;
	logic [1:0] src, lvl_b, lvl_a, source_force_select, hysteresis_select;
	logic thr1_select, thr2_select, charger_off;
	int n_mismatch = 0;
	int total_checks = 0;

	// open-drain data wire with pull-up
	assign sda_wire = (sda_pull || (sda_oe && sda_out === 1'b0)) ? 1'b0 : 1'b1;

	dbs_bus_master dbs_bus_master_inst (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda(sda_wire));

	dbs_serial_port dbs_serial_port_inst (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_select_high_pin(addr_hi), .addr_select_low_pin(addr_lo),
		.hw_reset_n_in(hw_rst_n), .battery_a_present_pin(bat_a), .battery_b_present_pin(bat_b),
		.supply_source_state(src), .batt_b_level_field(lvl_b), .batt_a_level_field(lvl_a),
		.irq_n_out(irq_n_out), .power_path_en(power_path_en), .source_force_select(source_force_select),
		.hysteresis_select(hysteresis_select), .thr1_select(thr1_select), .thr2_select(thr2_select),
		.charger_off(charger_off));

	////////////////////////////////////////////////////////////
	// comparison, verdict and small helpers
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	function automatic logic [6:0] dev_addr();
		return {dbs_pkg::DEV_ADDR_HI, addr_hi, addr_lo};
	endfunction

	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic [2:0] nak;
		dbs_bus_master_inst.write_reg(dev_addr(), r, d, nak);
		check("write acks", {5'h00, nak}, 8'h00);
	endtask

	// two bytes are read: the register is repeated while the master acknowledges
	task automatic rd(input logic [7:0] r, input logic [7:0] exp);
		logic [2:0] nak;
		logic [15:0] d;
		dbs_bus_master_inst.read_reg(dev_addr(), r, d, nak);
		check("read acks", {5'h00, nak}, 8'h00);
		check("read data", d[15:8], exp);
		check("read repeat", d[7:0], exp);
	endtask

	// configuration pins against the expected six-bit field
	task automatic cfg_pins(input logic [5:0] e);
		check("config pins", {1'b0, charger_off, source_force_select, hysteresis_select, thr1_select,
			thr2_select}, {1'b0, e[5], e});
	endtask

	////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		check("irq after reset", {7'h00, irq_n_out}, 8'h01);
		check("power after reset", {7'h00, power_path_en}, 8'h01);
		cfg_pins(6'h00);
		rd(dbs_pkg::REG_CONFIG, 8'h00);
	endtask

	task automatic t_cfg();
		logic [7:0] vals [3] = '{8'h2a, 8'h15, 8'h3f};
		foreach (vals[i])
		begin
			wr(dbs_pkg::REG_CONFIG, vals[i]);
			cfg_pins(vals[i][5:0]);
			rd(dbs_pkg::REG_CONFIG, {2'b00, vals[i][5:0]});
		end
	endtask

	// every select pin setting, a wrong address is never acknowledged
	task automatic t_addr();
		logic [2:0] nak;
		logic [6:0] bad;
		for (int i = 0; i < 4; i++)
		begin
			{addr_hi, addr_lo} <= i[1:0];
			tick(10);
			bad = (i == 3) ? {dbs_pkg::DEV_ADDR_HI ^ 5'h10, i[1:0]} : {dbs_pkg::DEV_ADDR_HI, ~i[1:0]};
			dbs_bus_master_inst.write_reg(bad, dbs_pkg::REG_CONFIG, 8'h00, nak);
			check("wrong address nak", {5'h00, nak}, 8'h07);
			wr(8'h05, 8'h00);
			cfg_pins(6'h3f);
		end
	endtask

	// status changes raise the interrupt, the state read clears it
	task automatic t_state();
		logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
		for (int k = 0; k < 3; k++)
		begin
			bat_b <= k[0];
			bat_a <= ~k[0];
			src <= codes[k];
			lvl_b <= k[1:0];
			lvl_a <= ~k[1:0];
			tick(10);
			check("irq on change", {7'h00, irq_n_out}, 8'h00);
			rd(dbs_pkg::REG_STATE, {k[0], ~k[0], codes[k], k[1:0], ~k[1:0]});
			check("irq after read", {7'h00, irq_n_out}, 8'h01);
		end
		wr(dbs_pkg::REG_STATE, 8'hff);
		rd(dbs_pkg::REG_STATE, {1'b0, 1'b1, 2'b11, 2'b10, 2'b01});
		// a one-cycle spike on an id pin is no status change
		bat_b <= 1'b1;
		tick(1);
		bat_b <= 1'b0;
		tick(10);
		check("irq after spike", {7'h00, irq_n_out}, 8'h01);
	endtask

	task automatic t_softrst();
		wr(dbs_pkg::REG_SOFT_RESET, 8'h01);
		cfg_pins(6'h3f);
		rd(dbs_pkg::REG_SOFT_RESET, 8'h00);
		wr(dbs_pkg::REG_SOFT_RESET, 8'h00);
		cfg_pins(6'h00);
		rd(dbs_pkg::REG_CONFIG, 8'h00);
	endtask

	task automatic t_hwrst();
		wr(dbs_pkg::REG_CONFIG, 8'h2a);
		hw_rst_n <= 1'b0;
		tick(8);
		check("power in reset", {7'h00, power_path_en}, 8'h00);
		cfg_pins(6'h00);
		hw_rst_n <= 1'b1;
		tick(10);
		check("power after reset", {7'h00, power_path_en}, 8'h01);
		rd(dbs_pkg::REG_CONFIG, 8'h00);
	endtask

	////////////////////////////////////////////////////////////
	// clock, watchdog and main sequence
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial
	begin
		repeat (90000) @(posedge clock);
		n_mismatch++;
		test_done();
	end

	initial
	begin
		sys_rst = 1'b1;
		hw_rst_n = 1'b1;
		{addr_hi, addr_lo} = 2'b10;
		{bat_a, bat_b, src, lvl_b, lvl_a} = 8'h00;
		tick(20);
		sys_rst <= 1'b0;
		tick(10);
		t_reset();
		t_cfg();
		t_addr();
		t_state();
		t_softrst();
		t_hwrst();
		test_done();
	end
endmodule
